/* rtl/asf_pkg.sv */
// constants, range codes and carrier structs for the sequencer register block
// assumes one 200 MHz clock and 32-bit register accesses from the host window
// Summary of operation
// [RL1] byte 0xFF at offset zero resets board
// [RL2] dac word: command, channel, 16-bit code
// [RL3] base clock register returns start clock hertz
// [RL4] base clock read-only, full word only
// [RL5] divisor register sets timed start period
// [RL6] software computes divisor as base over rate
// [RL7] two gain registers, eight nybbles each
// [RL8] gain codes used only in advanced mode
// [RL9] gain code to input range encoding
// [RL10] software never writes gain code six
// [RL11] 12-bit threshold raises almost-full level
// [RL12] software mode: 32-bit entries, 4095 deep
// [RL13] timed modes: 64-bit entries, 8190 conversions
// [RL14] count reports single conversions in software mode
// [RL15] timed count reports pairs, two reads each
// [RL16] dma moves native 64-bit entries
// [RL17] software writes zero to reserved bits
// [RL18] divisor zero: start bit gives one start
// [RL19] empty data read sets invalid flag
// [RL20] count follows every push and pop
// [RL21] almost-full holds while at or above threshold
package asf_pkg;

	// register offsets
	localparam logic [7:0] ASF_OFS_RESET   = 8'h00;
	localparam logic [7:0] ASF_OFS_DAC     = 8'h04;
	localparam logic [7:0] ASF_OFS_BASECLK = 8'h0C;
	localparam logic [7:0] ASF_OFS_DIV     = 8'h10;
	localparam logic [7:0] ASF_OFS_GAIN_LO = 8'h18;
	localparam logic [7:0] ASF_OFS_GAIN_HI = 8'h1C;
	localparam logic [7:0] ASF_OFS_THRESH  = 8'h20;
	localparam logic [7:0] ASF_OFS_COUNT   = 8'h28;
	localparam logic [7:0] ASF_OFS_DATA    = 8'h30;
	localparam logic [7:0] ASF_OFS_CTRL    = 8'h38;

	// field layouts
	localparam logic [7:0]  ASF_RESET_KEY   = 8'hFF;
	localparam int          ASF_DAC_USED_W  = 24;
	localparam int          ASF_GAIN_FLD_W  = 4;
	localparam int          ASF_GAIN_CODE_W = 3;
	localparam int          ASF_NUM_INPUTS  = 16;
	localparam int          ASF_THRESH_W    = 12;
	localparam int          ASF_CTRL_START  = 16;
	localparam logic [31:0] ASF_EMPTY_WORD  = 32'h80000000;

	// reset values
	localparam logic [31:0] ASF_DAC_RST    = 32'h00000000;
	localparam logic [31:0] ASF_DIV_RST    = 32'h00000000;
	localparam logic [31:0] ASF_GAIN_RST   = 32'h00000000;
	localparam logic [11:0] ASF_THRESH_RST = 12'h000;

	// capacities in 32-bit words and clock rate
	localparam int          ASF_SW_MAX_WORDS    = 4095;
	localparam int          ASF_TIMED_MAX_WORDS = 8190;
	localparam logic [31:0] ASF_SYS_CLK_HZ      = 32'h0BEBC200;

	typedef enum logic [2:0] {
		ASF_RNG_12V0  = 3'b000,
		ASF_RNG_5V0   = 3'b001,
		ASF_RNG_2V5   = 3'b010,
		ASF_RNG_1V25  = 3'b011,
		ASF_RNG_0V625 = 3'b100,
		ASF_RNG_0V312 = 3'b101,
		ASF_RNG_RSVD  = 3'b110,
		ASF_RNG_10V0  = 3'b111
	} asf_range_t;

	typedef enum logic [1:0] {
		ASF_TMR_IDLE = 2'b00,
		ASF_TMR_RUN  = 2'b01
	} asf_tmr_t;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [3:0]  be;
		logic [31:0] wdata;
	} asf_req_t;

	typedef struct packed {
		logic        valid;
		logic [31:0] rdata;
	} asf_rsp_t;

	typedef struct packed {
		logic        valid;
		logic [63:0] data;
	} asf_dma_t;

endpackage

/* rtl/asf_skid.sv */
// two-entry buffer in front of the conversion store
// assumes the same clock, enable and reset as its parent
`timescale 1ns/100ps
module asf_skid #(
	parameter int W = 32
) (
	// clock and reset
	input  wire logic         sys_clk,
	input  wire logic         rst_b,
	input  wire logic         ce,
	input  wire logic         clr,
	// fill side
	input  wire logic         in_valid,
	input  wire logic [W-1:0] in_data,
	output logic              in_ready,
	// drain side
	output logic              out_valid,
	output logic [W-1:0]      out_data,
	input  wire logic         out_ready
);
	typedef struct packed {
		logic [W-1:0] d0;
		logic [W-1:0] d1;
		logic [1:0]   cnt;
	} asf_skid_st_t;

	asf_skid_st_t s_q;
	asf_skid_st_t s_d;
	logic         push;
	logic         pop;

	// no word is taken while frozen or being cleared, so none is lost
	assign in_ready  = ce && !clr && (s_q.cnt != 2'h2);
	assign out_valid = (s_q.cnt != 2'h0);
	assign out_data  = s_q.d0;
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_comb begin
		s_d = s_q;
		if (pop) begin
			s_d.d0  = s_q.d1;
			s_d.cnt = s_q.cnt - 2'h1;
		end
		if (push) begin
			if (s_d.cnt == 2'h0) begin
				s_d.d0 = in_data;
			end else begin
				s_d.d1 = in_data;
			end
			s_d.cnt = s_d.cnt + 2'h1;
		end
		if (clr) begin
			s_d = '0;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			s_q <= '0;
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	a_skid_bound: assert property (@(posedge sys_clk) disable iff (!rst_b) s_q.cnt != 2'h3)
		else $error("buffer count out of range");
	a_skid_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
		out_valid && !out_ready && !clr |=> out_valid && $stable(out_data))
		else $error("stalled word lost or changed");
endmodule

/* rtl/asf_seq_regs.sv */
// sequencer registers, start timer and conversion store
// assumes host accesses are one-cycle strobes; read answers one cycle later
`timescale 1ns/100ps
module asf_seq_regs #(
	parameter int          DEPTH       = 8192,
	parameter int          AW          = 13,
	parameter logic [31:0] BASE_CLK_HZ = asf_pkg::ASF_SYS_CLK_HZ
) (
	// clock and reset
	input  wire logic               sys_clk,
	input  wire logic               rst_b,
	input  wire logic               ce,
	// host register access
	input  wire asf_pkg::asf_req_t  reg_req,
	output asf_pkg::asf_rsp_t       reg_rsp,
	// conversion results in
	input  wire logic               sample_valid,
	input  wire logic [31:0]        sample_data,
	output logic                    sample_ready,
	// dma drain
	input  wire logic               dma_req,
	output logic                    dma_ready,
	output asf_pkg::asf_dma_t       dma_out,
	// sequencer side
	input  wire logic               adv_seq_mode,
	input  wire logic [3:0]         analog_input_channel,
	input  wire asf_pkg::asf_range_t basic_range,
	output asf_pkg::asf_range_t     range_code,
	output logic                    conv_start,
	output logic                    run,
	// dac and board
	output logic [31:0]             dac_word,
	output logic                    dac_load,
	output logic                    almost_full_level,
	output logic                    board_reset
);
	import asf_pkg::*;

	typedef struct packed {
		logic [31:0] dac;
		logic [31:0] div;
		logic [31:0] gain_lo;
		logic [31:0] gain_hi;
		logic [11:0] thresh;
		logic        run;
		asf_tmr_t    tmr;
		logic [31:0] tcnt;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] wcnt;
		asf_rsp_t    rsp;
		asf_dma_t    dma;
		logic        conv;
		logic        dac_ld;
		logic        soft_rst;
		asf_range_t  rng;
		logic        af;
	} asf_state_t;

	localparam asf_state_t ST_RST = '{dac: ASF_DAC_RST, div: ASF_DIV_RST,
		gain_lo: ASF_GAIN_RST, gain_hi: ASF_GAIN_RST, thresh: ASF_THRESH_RST,
		tmr: ASF_TMR_IDLE, rng: ASF_RNG_12V0, default: '0};

	asf_state_t  s_q;
	asf_state_t  s_d;
	logic [31:0] mem [DEPTH];
	logic [63:0] gains;
	logic [2:0]  chan_code [ASF_NUM_INPUTS];
	logic        sw_mode;
	logic        buf_valid;
	logic [31:0] buf_data;
	logic        buf_ready;
	logic        push;
	logic        reg_pop;
	logic        dma_go;
	logic [1:0]  pop_n;
	logic [AW:0] cap;
	logic [AW:0] cnt_full;
	logic [11:0] count12;
	logic [AW-1:0] rp_nx;
	logic [63:0] dma_word;
	logic        live;

	asf_skid #(
		.W(32)
	) u_skid (
		.sys_clk   (sys_clk),
		.rst_b     (rst_b),
		.ce        (ce),
		.clr       (s_q.soft_rst),
		.in_valid  (sample_valid),
		.in_data   (sample_data),
		.in_ready  (sample_ready),
		.out_valid (buf_valid),
		.out_data  (buf_data),
		.out_ready (buf_ready)
	);

	// per-input range fields
	assign gains = {s_q.gain_hi, s_q.gain_lo};
	for (genvar gi = 0; gi < ASF_NUM_INPUTS; gi++) begin : g_chan
		assign chan_code[gi] = gains[gi*ASF_GAIN_FLD_W +: ASF_GAIN_CODE_W]; // [RL7]
	end

	assign sw_mode  = (s_q.div == 32'h0);
	assign cap      = sw_mode ? (AW+1)'(ASF_SW_MAX_WORDS)             // [RL12]
	                          : (AW+1)'(ASF_TIMED_MAX_WORDS);         // [RL13]
	assign buf_ready = (s_q.wcnt < cap) && !s_q.soft_rst;
	assign push     = buf_valid && buf_ready;
	assign cnt_full = sw_mode ? s_q.wcnt : (s_q.wcnt >> 1);          // [RL14] [RL15]
	assign count12  = cnt_full[11:0];
	assign rp_nx    = s_q.rp + AW'(1);
	assign dma_word = sw_mode ? {32'h0, mem[s_q.rp]} : {mem[rp_nx], mem[s_q.rp]}; // [RL16]
	assign reg_pop  = reg_req.rd && (reg_req.addr == ASF_OFS_DATA) && (s_q.wcnt != '0);
	assign dma_ready = ce && !reg_pop && !s_q.soft_rst &&
		(sw_mode ? (s_q.wcnt >= (AW+1)'(1)) : (s_q.wcnt >= (AW+1)'(2)));
	assign dma_go   = dma_req && dma_ready;
	assign pop_n    = reg_pop ? 2'h1 : (dma_go ? (sw_mode ? 2'h1 : 2'h2) : 2'h0);
	assign live     = ce && rst_b && !s_q.soft_rst;

	always_comb begin
		s_d = s_q;
		s_d.conv      = 1'b0;
		s_d.dac_ld    = 1'b0;
		s_d.soft_rst  = 1'b0;
		s_d.rsp.valid = 1'b0;
		s_d.dma.valid = 1'b0;
		// start timer
		case (s_q.tmr)
			ASF_TMR_IDLE: begin
				s_d.tcnt = 32'h0;
			end
			ASF_TMR_RUN: begin
				if (sw_mode) begin
					s_d.tmr = ASF_TMR_IDLE;
					s_d.run = 1'b0;
				end else if (s_q.tcnt >= s_q.div - 32'h1) begin
					s_d.tcnt = 32'h0;
					s_d.conv = 1'b1; // [RL5]
				end else begin
					s_d.tcnt = s_q.tcnt + 32'h1;
				end
			end
			default: begin
				s_d.tmr = ASF_TMR_IDLE;
			end
		endcase
		// register writes
		if (reg_req.wr) begin
			case (reg_req.addr)
				ASF_OFS_RESET: begin
					if (reg_req.be[0] && reg_req.wdata[7:0] == ASF_RESET_KEY) begin
						s_d.soft_rst = 1'b1; // [RL1]
					end
				end
				ASF_OFS_DAC: begin
					s_d.dac    = {8'h00, reg_req.wdata[ASF_DAC_USED_W-1:0]}; // [RL2]
					s_d.dac_ld = 1'b1;
				end
				ASF_OFS_DIV: begin
					s_d.div = reg_req.wdata;
				end
				ASF_OFS_GAIN_LO: begin
					s_d.gain_lo = reg_req.wdata;
				end
				ASF_OFS_GAIN_HI: begin
					s_d.gain_hi = reg_req.wdata;
				end
				ASF_OFS_THRESH: begin
					s_d.thresh = reg_req.wdata[ASF_THRESH_W-1:0]; // [RL11]
				end
				ASF_OFS_CTRL: begin
					if (reg_req.wdata[ASF_CTRL_START]) begin
						s_d.conv = 1'b1; // [RL18]
						if (!sw_mode) begin
							s_d.tmr  = ASF_TMR_RUN;
							s_d.run  = 1'b1;
							s_d.tcnt = 32'h0;
						end
					end else begin
						s_d.tmr = ASF_TMR_IDLE;
						s_d.run = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end
		// register reads
		if (reg_req.rd) begin
			s_d.rsp.valid = 1'b1;
			case (reg_req.addr)
				ASF_OFS_DAC:     s_d.rsp.rdata = s_q.dac;
				ASF_OFS_BASECLK: s_d.rsp.rdata = (reg_req.be == 4'hF) ? BASE_CLK_HZ : 32'h0; // [RL3] [RL4]
				ASF_OFS_DIV:     s_d.rsp.rdata = s_q.div;
				ASF_OFS_GAIN_LO: s_d.rsp.rdata = s_q.gain_lo;
				ASF_OFS_GAIN_HI: s_d.rsp.rdata = s_q.gain_hi;
				ASF_OFS_THRESH:  s_d.rsp.rdata = {20'h0, s_q.thresh};
				ASF_OFS_COUNT:   s_d.rsp.rdata = {20'h0, count12}; // [RL14]
				ASF_OFS_DATA:    s_d.rsp.rdata = reg_pop ? mem[s_q.rp] : ASF_EMPTY_WORD; // [RL19]
				ASF_OFS_CTRL:    s_d.rsp.rdata = {15'h0, s_q.run, 16'h0};
				default:         s_d.rsp.rdata = 32'h0;
			endcase
		end
		// store pointers and occupancy
		if (dma_go) begin
			s_d.dma.valid = 1'b1;
			s_d.dma.data  = dma_word; // [RL16]
		end
		if (push) begin
			s_d.wp = s_q.wp + AW'(1);
		end
		s_d.rp   = s_q.rp + AW'(pop_n);
		s_d.wcnt = s_q.wcnt + (AW+1)'(push) - (AW+1)'(pop_n); // [RL20]
		s_d.af   = (count12 >= s_q.thresh);                    // [RL21] [RL11]
		s_d.rng  = adv_seq_mode ? asf_range_t'(chan_code[analog_input_channel]) // [RL8] [RL9]
		                        : basic_range;
		if (s_q.soft_rst) begin
			s_d = ST_RST; // [RL1]
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			s_q <= ST_RST;
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (ce && push) begin
			mem[s_q.wp] <= buf_data;
		end
	end

	assign reg_rsp           = s_q.rsp;
	assign dma_out           = s_q.dma;
	assign range_code        = s_q.rng;
	assign conv_start        = s_q.conv;
	assign run               = s_q.run;
	assign dac_word          = s_q.dac;
	assign dac_load          = s_q.dac_ld;
	assign almost_full_level = s_q.af;
	assign board_reset       = s_q.soft_rst;

	// checks
	sequence s_sw_start;
		live && reg_req.wr && reg_req.addr == ASF_OFS_CTRL &&
			reg_req.wdata[ASF_CTRL_START] && sw_mode;
	endsequence
	sequence s_quiet;
		ce && !reg_req.wr;
	endsequence

	a_reset_key: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RL1]
		live && reg_req.wr && reg_req.addr == ASF_OFS_RESET && reg_req.be[0] &&
		reg_req.wdata[7:0] == ASF_RESET_KEY |=> board_reset ##1 (!ce || s_q.div == 32'h0))
		else $error("reset key did not reset board");
	a_dac_fields: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RL2]
		live && reg_req.wr && reg_req.addr == ASF_OFS_DAC |=>
		dac_word == {8'h00, $past(reg_req.wdata[23:0])} && dac_load)
		else $error("dac word fields wrong");
	a_base_clk: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RL3]
		live && reg_req.rd && reg_req.addr == ASF_OFS_BASECLK && reg_req.be == 4'hF |=>
		reg_rsp.valid && reg_rsp.rdata == BASE_CLK_HZ)
		else $error("base clock read wrong");
	a_base_part: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RL4]
		live && reg_req.rd && reg_req.addr == ASF_OFS_BASECLK && reg_req.be != 4'hF |=>
		reg_rsp.rdata == 32'h0)
		else $error("partial base clock read answered");
	a_rate_tick: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RL5]
		live && !reg_req.wr && s_q.tmr == ASF_TMR_RUN && !sw_mode &&
		s_q.tcnt == s_q.div - 32'h1 |=> conv_start ##1 (!ce || s_q.tcnt <= 32'h1))
		else $error("timed start missed");
	a_gain_adv: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RL8]
		live && adv_seq_mode |=> range_code == $past(chan_code[analog_input_channel]))
		else $error("advanced gain not applied");
	a_gain_basic: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RL8]
		live && !adv_seq_mode |=> range_code == $past(basic_range))
		else $error("gain used outside advanced mode");
	a_cap_limit: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RL12]
		push |-> s_q.wcnt < (sw_mode ? (AW+1)'(ASF_SW_MAX_WORDS) : (AW+1)'(ASF_TIMED_MAX_WORDS)))
		else $error("store filled past capacity");
	a_count_read: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RL15]
		live && reg_req.rd && reg_req.addr == ASF_OFS_COUNT |=>
		reg_rsp.rdata[11:0] == ($past(sw_mode) ? $past(s_q.wcnt[11:0]) : $past(s_q.wcnt[12:1])))
		else $error("count register wrong");
	a_dma_pair: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RL16]
		live && dma_go && !sw_mode |=> dma_out.valid && dma_out.data == $past(dma_word) ##0
		s_q.wcnt == $past(s_q.wcnt) + (AW+1)'($past(push)) - (AW+1)'(2))
		else $error("dma entry not 64 bits");
	a_sw_single: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RL18]
		s_sw_start ##1 s_quiet |-> conv_start ##1 !conv_start)
		else $error("software start not single");
	a_empty_read: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RL19]
		live && reg_req.rd && reg_req.addr == ASF_OFS_DATA && s_q.wcnt == '0 |=>
		reg_rsp.rdata[31])
		else $error("empty read not flagged");
	a_count_track: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RL20]
		live |=> s_q.wcnt == $past(s_q.wcnt) + (AW+1)'($past(push)) - (AW+1)'($past(pop_n)))
		else $error("occupancy lagging");
	a_af_level: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RL21]
		live |=> almost_full_level == ($past(count12) >= $past(s_q.thresh)))
		else $error("almost full level wrong");
endmodule

/* tb/test_asf_seq_regs.sv */
// self-checking bench for the sequencer register block, queue model of the store
// assumes asf_pkg is compiled first; the bench drives every input port of the block itself
`timescale 1ns/100ps
module test_asf_seq_regs;
	import asf_pkg::*;
	logic             sys_clk, rst_b, ce, sample_valid, sample_ready, dma_req, dma_ready;
	logic             adv_seq_mode, conv_start, run, dac_load, almost_full_level, board_reset;
	asf_req_t         reg_req;
	asf_rsp_t         reg_rsp;
	asf_dma_t         dma_out;
	logic [3:0]       analog_input_channel;
	asf_range_t       basic_range, range_code;
	logic [31:0]      sample_data, dac_word, rd_v, dac_v;
	logic [63:0]      gains;
	logic [31:0]      q[$];
	int               failures, checks_done, starts, resets, timed, c;

	asf_seq_regs u_asf_seq_regs (
		.sys_clk(sys_clk), .rst_b(rst_b), .ce(ce), .reg_req(reg_req), .reg_rsp(reg_rsp),
		.sample_valid(sample_valid), .sample_data(sample_data), .sample_ready(sample_ready),
		.dma_req(dma_req), .dma_ready(dma_ready), .dma_out(dma_out),
		.adv_seq_mode(adv_seq_mode), .analog_input_channel(analog_input_channel),
		.basic_range(basic_range), .range_code(range_code), .conv_start(conv_start),
		.run(run), .dac_word(dac_word), .dac_load(dac_load),
		.almost_full_level(almost_full_level), .board_reset(board_reset)
	);

	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	// event counters seen at every rising edge
	always @(posedge sys_clk) begin
		if (conv_start === 1'b1) starts++;
		if (board_reset === 1'b1) resets++;
	end

	task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	// one-cycle strobe; a read answer is taken one cycle after the taking edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] b,
			input logic [31:0] d);
		reg_req <= '{wr: w, rd: !w, addr: a, be: b, wdata: d};
		@(posedge sys_clk);
		reg_req <= '0;
		@(posedge sys_clk);
		if (!w) begin
			check("rsp_valid", reg_rsp.valid, 1);
			rd_v = reg_rsp.rdata;
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, 4'hF, d);
	endtask

	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 4'hF, '0);
		check(nm, rd_v, e);
	endtask

	task automatic cnt_chk();
		rdc("count", ASF_OFS_COUNT, timed ? q.size() / 2 : q.size());
	endtask

	task automatic pop_rd();
		rdc("fifo_word", ASF_OFS_DATA, q.pop_front());
	endtask

	task automatic starts_chk(input string nm, input int e);
		@(negedge sys_clk);
		check(nm, 64'(starts), 64'(e));
		@(posedge sys_clk);
	endtask

	// offer up to n random words, recording each one the block accepts
	task automatic stream(input int n);
		int k;
		k = 0;
		sample_valid <= 1'b1;
		sample_data <= $urandom;
		for (int i = 0; i < 6000 && k < n; i++) begin
			@(posedge sys_clk);
			if (sample_ready === 1'b1) begin
				q.push_back(sample_data);
				k++;
				sample_data <= $urandom;
			end
		end
		sample_valid <= 1'b0;
	endtask

	task automatic dma_get();
		int i;
		logic [63:0] e;
		i = 0;
		dma_req <= 1'b1;
		do begin
			@(posedge sys_clk);
			i++;
		end while (dma_ready !== 1'b1 && i < 50);
		dma_req <= 1'b0;
		@(posedge sys_clk);
		e = timed ? {q[1], q[0]} : {32'h0, q[0]};
		void'(q.pop_front());
		if (timed) void'(q.pop_front());
		check("dma_valid", dma_out.valid, 1);
		check("dma_data", dma_out.data, e);
	endtask

	initial begin
		repeat (60000) @(posedge sys_clk);
		failures++;
		summarize();
	end

	initial begin
		void'($urandom(32'h5491));
		rst_b = 1'b0; ce = 1'b1; reg_req = '0; sample_valid = 1'b0; sample_data = '0;
		dma_req = 1'b0; adv_seq_mode = 1'b0; analog_input_channel = '0;
		basic_range = ASF_RNG_12V0; timed = 0;
		repeat (4) @(posedge sys_clk);
		rst_b <= 1'b1;
		idle(2);
		check("af_zero", almost_full_level, 1);
		rdc("dac_rst", ASF_OFS_DAC, ASF_DAC_RST);
		rdc("div_rst", ASF_OFS_DIV, ASF_DIV_RST);
		rdc("gain_rst", ASF_OFS_GAIN_HI, ASF_GAIN_RST);
		rdc("thr_rst", ASF_OFS_THRESH, 32'(ASF_THRESH_RST));
		wr(ASF_OFS_BASECLK, 32'h1234);
		rdc("base_clk", ASF_OFS_BASECLK, ASF_SYS_CLK_HZ);
		bus(1'b0, ASF_OFS_BASECLK, 4'h1, '0);
		check("base_part", rd_v, 0);
		rdc("unmapped", 8'h60, 32'h0);
		bus(1'b0, ASF_OFS_DATA, 4'hF, '0);
		check("empty_flag", rd_v[31], 1);
		dac_v = $urandom & 32'h00FFFFFF;
		wr(ASF_OFS_DAC, dac_v);
		check("dac_load", dac_load, 1);
		check("dac_word", dac_word, dac_v);
		rdc("dac_rd", ASF_OFS_DAC, dac_v);
		gains = 64'h75432100;
		for (int i = 8; i < 16; i++) begin
			c = $urandom % 7;
			gains[4*i +: 3] = (c == 6) ? 3'd7 : 3'(c);
		end
		wr(ASF_OFS_GAIN_LO, gains[31:0]);
		wr(ASF_OFS_GAIN_HI, gains[63:32]);
		rdc("gain_lo", ASF_OFS_GAIN_LO, gains[31:0]);
		rdc("gain_hi", ASF_OFS_GAIN_HI, gains[63:32]);
		adv_seq_mode <= 1'b1;
		for (int ch = 0; ch < 16; ch++) begin
			analog_input_channel <= 4'(ch);
			idle(3);
			check("range_adv", range_code, 64'(gains[4*ch +: 3]));
		end
		adv_seq_mode <= 1'b0;
		basic_range <= ASF_RNG_5V0;
		idle(3);
		check("range_basic", range_code, ASF_RNG_5V0);
		starts_chk("pre", 0);
		wr(ASF_OFS_CTRL, 32'h00010000);
		idle(20);
		starts_chk("sw_starts", 1);
		wr(ASF_OFS_THRESH, 32'h3);
		stream(2);
		idle(4);
		check("af_below", almost_full_level, 0);
		stream(1);
		idle(4);
		check("af_at", almost_full_level, 1);
		cnt_chk();
		pop_rd();
		idle(3);
		check("af_clear", almost_full_level, 0);
		cnt_chk();
		pop_rd();
		pop_rd();
		cnt_chk();
		wr(ASF_OFS_DIV, ASF_SYS_CLK_HZ / (ASF_SYS_CLK_HZ / 32'd5));
		timed = 1;
		rdc("div_rd", ASF_OFS_DIV, 32'd5);
		starts_chk("pre", 1);
		@(negedge sys_clk);
		starts = 0;
		@(posedge sys_clk);
		wr(ASF_OFS_CTRL, 32'h00010000);
		idle(22);
		starts_chk("timed_starts", 5);
		check("run", run, 1);
		wr(ASF_OFS_CTRL, 32'h0);
		@(negedge sys_clk);
		starts = 0;
		idle(12);
		starts_chk("stopped", 0);
		stream(6);
		idle(5);
		cnt_chk();
		ce <= 1'b0;
		dma_req <= 1'b1;
		idle(4);
		check("ce_frozen", dma_out.valid, 0);
		check("ce_no_take", dma_ready, 0);
		ce <= 1'b1;
		dma_req <= 1'b0;
		cnt_chk();
		pop_rd();
		pop_rd();
		dma_get();
		dma_get();
		cnt_chk();
		bus(1'b1, ASF_OFS_RESET, 4'h1, 32'hFE);
		idle(3);
		check("no_reset", 64'(resets), 0);
		bus(1'b1, ASF_OFS_RESET, 4'h1, 32'hFF);
		idle(3);
		check("board_reset", 64'(resets), 1);
		timed = 0;
		rdc("div_clr", ASF_OFS_DIV, 32'h0);
		rdc("gain_clr", ASF_OFS_GAIN_LO, 32'h0);
		wr(ASF_OFS_THRESH, 32'd4095);
		stream(5000);
		idle(4);
		check("accepted", 64'(q.size()), 64'(ASF_SW_MAX_WORDS + 2));
		check("ready_full", sample_ready, 0);
		check("af_full", almost_full_level, 1);
		rdc("count_full", ASF_OFS_COUNT, 32'(ASF_SW_MAX_WORDS));
		while (q.size() > 0) dma_get();
		idle(4);
		cnt_chk();
		check("af_empty", almost_full_level, 0);
		summarize();
	end
endmodule
